/* common/ccs_defines.svh */
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH
// register byte offsets
`define CCS_OFF_CLKSEL   12'h000
`define CCS_OFF_OSCEN    12'h004
`define CCS_OFF_XOSC     12'h008
`define CCS_OFF_CAL      12'h00C
`define CCS_OFF_STATUS   12'h010
`define CCS_OFF_CFD      12'h014
`define CCS_OFF_SLEEP    12'h018
`define CCS_OFF_PR       12'h01C
// field positions
`define CCS_SEL_LSB      0
`define CCS_SEL_MSB      2
`define CCS_DIV_LSB      4
`define CCS_DIV_MSB      7
`define CCS_XMODE_LSB    0
`define CCS_XMODE_MSB    1
`define CCS_PLLF_LSB     8
`define CCS_PLLF_MSB     12
`define CCS_PLLREF_LSB   14
`define CCS_PLLREF_MSB   15
`define CCS_FREQUENCY_CALIBRATION_LOOP_LSB     8
`define CCS_FREQUENCY_CALIBRATION_LOOP_MSB     9
`define CCS_CAL_MSB      7
`define CCS_ST_FAIL      8
`define CCS_CFD_EN       0
`define CCS_SLP_EN       0
`define CCS_SLP_MLSB     1
`define CCS_SLP_MMSB     3
// reset values and limits
`define CCS_DIV_MAX      4'h0_B
`define CCS_PLLF_RST     5'h0_1
`define CCS_HALT_CYC     3'h4
`define CCS_LF_DIV       32
`endif

/* common/ccs_pkg.sv */
package ccs_pkg;
   // system clock sources, index into the source tick vector
   typedef enum logic [2:0] {
      CCS_RC2M, CCS_RC32M, CCS_RC32K, CCS_XOSC, CCS_PLL
   } ccs_src_e;
   // sleep modes as written to the mode field
   typedef enum logic [2:0] {
      CCS_IDLE, CCS_PDOWN, CCS_PSAVE, CCS_STBY, CCS_ESTBY
   } ccs_smode_e;
   typedef enum logic [1:0] {CCS_ST_ACTIVE, CCS_ST_SLEEP, CCS_ST_HALT} ccs_state_e;
   localparam int CCS_NSRC = 5;
endpackage

/* common/ccs_presc_if.sv */
`timescale 1ns/1ps
interface ccs_presc_if;
   logic       src_tick;
   logic [3:0] div_exp;
   logic       per4_tick;
   logic       per2_tick;
   logic       cpu_tick;
   modport ctrl  (output src_tick, output div_exp, input per4_tick, per2_tick, cpu_tick);
   modport presc (input src_tick, input div_exp, output per4_tick, per2_tick, cpu_tick);
endinterface

/* logic/ccs_prescaler.sv */
`timescale 1ns/1ps
`include "ccs_defines.svh"
module ccs_prescaler
   import ccs_pkg::*;
(
   // clock and reset
   input wire logic     pclk,
   input wire logic     presetn,
   // tick chain
   ccs_presc_if.presc   pif
);
   logic [10:0] cnt;
   logic [1:0]  fast;
   logic [3:0]  div_q;
   wire  [10:0] limit = 11'((12'h001 << pif.div_exp) - 12'h001);
   wire         stage = pif.src_tick && (cnt >= limit);
   // one shared counter keeps the three ticks phase aligned
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt  <= '0;
         fast <= '0;
         div_q <= '0;
         pif.per4_tick <= 1'b0;
         pif.per2_tick <= 1'b0;
         pif.cpu_tick  <= 1'b0;
      end
      else
      begin
         div_q <= pif.div_exp;
         // a ratio change restarts the count, so no short period appears
         if (div_q != pif.div_exp || stage)
            cnt <= '0;
         else if (pif.src_tick)
            cnt <= cnt + 11'h001;
         if (stage)
            fast <= fast + 2'h1;
         pif.per4_tick <= stage;
         pif.per2_tick <= stage && fast[0];
         pif.cpu_tick  <= stage && (&fast);
      end
   end
   property p_fast_phase;
      @(posedge pclk) disable iff (!presetn) pif.cpu_tick |-> pif.per2_tick && pif.per4_tick;
   endproperty
   a_fast_phase: assert property (p_fast_phase) else $error("cpu tick out of phase");
   property p_div_range;
      @(posedge pclk) disable iff (!presetn) pif.per4_tick && $past(pif.per4_tick) |->
         $past(div_q) == '0;
   endproperty
   a_div_range: assert property (p_div_range) else $error("back to back ticks at ratio > 1");
endmodule // ccs_prescaler

/* logic/ccs_tick_div.sv */
`timescale 1ns/1ps
module ccs_tick_div #(
   parameter int DIV = 32
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // ticks
   input  wire logic in_tick,
   output logic      out_tick
);
   logic [$clog2(DIV)-1:0] cnt;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt      <= '0;
         out_tick <= 1'b0;
      end
      else
      begin
         if (in_tick)
            cnt <= (cnt == ($clog2(DIV))'(DIV - 1)) ? '0 : cnt + 1'b1;
         out_tick <= in_tick && (cnt == ($clog2(DIV))'(DIV - 1));
      end
   end
endmodule // ccs_tick_div

/* logic/ccs_clock_sleep_ctrl.sv */
`timescale 1ns/1ps
`include "ccs_defines.svh"
module ccs_clock_sleep_ctrl
   import ccs_pkg::*;
#(
   parameter int         NPER    = 8,
   parameter logic [7:0] CAL_RST = 8'h80
) (
   // clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   // oscillators
   input  wire logic [CCS_NSRC-1:0] src_tick,
   input  wire logic [CCS_NSRC-1:0] src_ready,
   input  wire logic                xosc_fail,
   input  wire logic                pll_fail,
   input  wire logic                slow_idle_tick,
   input  wire logic                slow_idle_used,
   input  wire logic                rc32k_tick,
   output logic      [CCS_NSRC-1:0] osc_en,
   output logic                     slow_idle_oscillator_en,
   output logic      [1:0]          frequency_calibration_loop_en,
   output logic      [1:0]          xosc_mode,
   output logic      [4:0]          pll_factor,
   output logic      [1:0]          pll_ref,
   output logic      [7:0]          rc32k_cal,
   output logic                     slow_1k_tick,
   output logic                     rc32k_1k_tick,
   // clock enables
   output logic                     cpu_clk_en,
   output logic                     nvm_clk_en,
   output logic      [NPER-1:0]     per_clk_en,
   output logic                     per2_clk_en,
   output logic                     per4_clk_en,
   output logic                     rtc_clk_run,
   output logic                     lcd_clk_run,
   output logic                     nmi,
   // cpu and wake
   input  wire logic                sleep_instr,
   input  wire logic                irq_any,
   input  wire logic                wake_async,
   input  wire logic                wake_rtc,
   input  wire logic                wake_lcd,
   input  wire logic                rtc_en,
   input  wire logic                lcd_en,
   input  wire logic                nvm_busy,
   output logic                     cpu_halt,
   output logic                     wake_pulse
);
   ccs_presc_if pif ();

   logic [2:0]       req_sel;
   ccs_src_e         cur_sel;
   logic [3:0]       div_exp;
   logic [4:0]       oscen;
   logic [1:0]       frequency_calibration_loop;
   logic [7:0]       cal;
   logic             cfd_en;
   logic             fail_flag;
   logic             xfail_q;
   logic             pfail_q;
   logic             sleep_en;
   logic [2:0]       smode;
   logic [NPER-1:0]  pr;
   ccs_state_e       state;
   logic [2:0]       halt_cnt;

   // apb decode
   wire setup    = psel && !penable;
   wire wr_en    = psel && penable && pready && pwrite;
   wire hit_sel  = paddr == `CCS_OFF_CLKSEL;
   wire hit_en   = paddr == `CCS_OFF_OSCEN;
   wire hit_x    = paddr == `CCS_OFF_XOSC;
   wire hit_cal  = paddr == `CCS_OFF_CAL;
   wire hit_st   = paddr == `CCS_OFF_STATUS;
   wire hit_cfd  = paddr == `CCS_OFF_CFD;
   wire hit_slp  = paddr == `CCS_OFF_SLEEP;
   wire hit_pr   = paddr == `CCS_OFF_PR;
   wire mapped   = hit_sel | hit_en | hit_x | hit_cal | hit_st | hit_cfd | hit_slp | hit_pr;
   wire [4:0] wr_pllf   = pwdata[`CCS_PLLF_MSB:`CCS_PLLF_LSB];
   wire [3:0] wr_div    = pwdata[`CCS_DIV_MSB:`CCS_DIV_LSB];
   wire [2:0] wr_sel    = pwdata[`CCS_SEL_MSB:`CCS_SEL_LSB];

   wire [31:0] rd_data =
      hit_sel ? {24'h00_0000, div_exp, 1'b0, req_sel} :
      hit_en  ? {22'h00_0000, frequency_calibration_loop, 3'h0, oscen} :
      hit_x   ? {16'h0000, pll_ref, 1'b0, pll_factor, 6'h00, xosc_mode} :
      hit_cal ? {24'h00_0000, cal} :
      hit_st  ? {16'h0000, 3'h0, fail_flag, 1'b0, cur_sel, 3'h0, src_ready} :
      hit_cfd ? {31'h0000_0000, cfd_en} :
      hit_slp ? {28'h000_0000, smode, sleep_en} :
      hit_pr  ? 32'(pr) : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         // answer registered one cycle after setup: zero wait states
         pready  <= setup;
         pslverr <= setup && !mapped;
         if (setup)
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
      end
   end

   // failure monitor
   wire xfail_new = xosc_fail && !xfail_q;
   wire pfail_new = pll_fail && !pfail_q;
   wire fail_hit  = cfd_en && (xfail_new || pfail_new);
   wire sel_ok    = wr_en && hit_sel && (wr_sel <= 3'(CCS_PLL));

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         req_sel    <= 3'(CCS_RC2M);
         div_exp    <= 4'h0;
         oscen      <= 5'h00;
         frequency_calibration_loop       <= 2'h0;
         xosc_mode  <= 2'h0;
         pll_factor <= `CCS_PLLF_RST;
         pll_ref    <= 2'h0;
         cal        <= CAL_RST;
         cfd_en     <= 1'b0;
         sleep_en   <= 1'b0;
         smode      <= 3'(CCS_IDLE);
         pr         <= '0;
      end
      else
      begin
         if (fail_hit)
            req_sel <= 3'(CCS_RC2M);
         else if (sel_ok)
            req_sel <= wr_sel;
         if (wr_en && hit_sel)
            div_exp <= (wr_div > `CCS_DIV_MAX) ? `CCS_DIV_MAX : wr_div;
         if (wr_en && hit_en)
         begin
            oscen <= pwdata[CCS_NSRC-1:0];
            frequency_calibration_loop  <= pwdata[`CCS_FREQUENCY_CALIBRATION_LOOP_MSB:`CCS_FREQUENCY_CALIBRATION_LOOP_LSB];
         end
         if (wr_en && hit_x)
         begin
            xosc_mode <= pwdata[`CCS_XMODE_MSB:`CCS_XMODE_LSB];
            pll_ref   <= pwdata[`CCS_PLLREF_MSB:`CCS_PLLREF_LSB];
            if (wr_pllf != 5'h00)
               pll_factor <= wr_pllf;
         end
         if (wr_en && hit_cal)
            cal <= pwdata[`CCS_CAL_MSB:0];
         if (wr_en && hit_cfd)
            cfd_en <= pwdata[`CCS_CFD_EN];
         if (wr_en && hit_slp)
         begin
            sleep_en <= pwdata[`CCS_SLP_EN];
            smode    <= pwdata[`CCS_SLP_MMSB:`CCS_SLP_MLSB];
         end
         if (wr_en && hit_pr)
            pr <= pwdata[NPER-1:0];
      end
   end

   // switch only once the new source is ready, on a prescaler boundary
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cur_sel   <= CCS_RC2M;
         fail_flag <= 1'b0;
         xfail_q   <= 1'b0;
         pfail_q   <= 1'b0;
         nmi       <= 1'b0;
      end
      else
      begin
         xfail_q <= xosc_fail;
         pfail_q <= pll_fail;
         // fail switches at once and raises nmi
         if (fail_hit)
            cur_sel <= CCS_RC2M;
         else if (req_sel != 3'(cur_sel) && src_ready[req_sel] && pif.per4_tick)
            cur_sel <= ccs_src_e'(req_sel);
         nmi <= fail_hit;
         // set wins over a write-one clear
         if (fail_hit)
            fail_flag <= 1'b1;
         else if (wr_en && hit_st && pwdata[`CCS_ST_FAIL])
            fail_flag <= 1'b0;
      end
   end

   assign pif.src_tick = src_tick[cur_sel];
   assign pif.div_exp  = div_exp;
   ccs_prescaler u_presc (
      .pclk    (pclk),
      .presetn (presetn),
      .pif     (pif)
   );

   ccs_tick_div #(.DIV(`CCS_LF_DIV)) u_slow_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .in_tick  (slow_idle_tick),
      .out_tick (slow_1k_tick)
   );
   ccs_tick_div #(.DIV(`CCS_LF_DIV)) u_rc32k_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .in_tick  (rc32k_tick),
      .out_tick (rc32k_1k_tick)
   );

   // sleep mode decode
   wire in_sleep  = state == CCS_ST_SLEEP;
   wire m_idle    = smode == 3'(CCS_IDLE);
   wire m_psave   = smode == 3'(CCS_PSAVE);
   wire m_stby    = smode == 3'(CCS_STBY);
   wire m_estby   = smode == 3'(CCS_ESTBY);
   wire mode_ok   = smode <= 3'(CCS_ESTBY);
   // rtc and display live on in save modes
   wire rtc_keep  = (m_psave || m_estby) && rtc_en;
   wire lcd_keep  = (m_psave || m_estby) && lcd_en;
   wire wake_hit  = m_idle ? irq_any :
                    (wake_async || (rtc_keep && wake_rtc) || (lcd_keep && wake_lcd));
   wire src_keep  = !in_sleep || m_idle || m_stby || m_estby;
   wire per_run   = !in_sleep || m_idle;
   wire cpu_run   = state == CCS_ST_ACTIVE;
   // entry only from active with enable set
   wire enter     = cpu_run && sleep_instr && sleep_en && mode_ok;

   always_ff @(posedge pclk or negedge presetn)
   begin
      // async reset leaves sleep for the reset vector
      if (!presetn)
      begin
         state    <= CCS_ST_ACTIVE;
         halt_cnt <= 3'h0;
      end
      else
      begin
         case (state)
            CCS_ST_ACTIVE:
               if (enter)
                  state <= CCS_ST_SLEEP;
            CCS_ST_SLEEP:
               if (wake_hit)
               begin
                  state    <= CCS_ST_HALT;
                  halt_cnt <= `CCS_HALT_CYC - 3'h1;
               end
            CCS_ST_HALT:
               if (halt_cnt == 3'h0)
                  state <= CCS_ST_ACTIVE;
               else
                  halt_cnt <= halt_cnt - 3'h1;
            default:
               state <= CCS_ST_ACTIVE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         osc_en                        <= '0;
         slow_idle_oscillator_en       <= 1'b0;
         frequency_calibration_loop_en <= 2'h0;
         rc32k_cal                     <= CAL_RST;
         cpu_clk_en                    <= 1'b0;
         nvm_clk_en                    <= 1'b0;
         per_clk_en                    <= '0;
         per2_clk_en                   <= 1'b0;
         per4_clk_en                   <= 1'b0;
         rtc_clk_run                   <= 1'b0;
         lcd_clk_run                   <= 1'b0;
         cpu_halt                      <= 1'b0;
         wake_pulse                    <= 1'b0;
      end
      else
      begin
         // outside power-down and power-save sleep: selected source kept on, others only if enabled
         osc_en <= src_keep ? (oscen | (CCS_NSRC'(1) << cur_sel)) : '0;
         slow_idle_oscillator_en       <= slow_idle_used;
         frequency_calibration_loop_en <= src_keep ? frequency_calibration_loop : 2'h0;
         rc32k_cal                     <= cal;
         cpu_clk_en  <= cpu_run && pif.cpu_tick;
         // in idle, standby and extended standby sleep and in the wake halt, ongoing programming finishes before nvm clock stops
         nvm_clk_en  <= (cpu_run || nvm_busy) && pif.cpu_tick;
         per_clk_en  <= {NPER{per_run && pif.cpu_tick}} & ~pr;
         per2_clk_en <= per_run && pif.per2_tick;
         per4_clk_en <= per_run && pif.per4_tick;
         rtc_clk_run <= !in_sleep || m_idle || rtc_keep;
         lcd_clk_run <= !in_sleep || m_idle || lcd_keep;
         // handler order left to the interrupt controller
         cpu_halt    <= in_sleep || (state == CCS_ST_HALT && halt_cnt != 3'h0);
         wake_pulse  <= in_sleep && wake_hit;
      end
   end

   property p_fail_switch;
      @(posedge pclk) disable iff (!presetn) fail_hit |=> cur_sel == CCS_RC2M && nmi && fail_flag;
   endproperty
   a_fail_switch: assert property (p_fail_switch) else $error("no fallback on failure");
   property p_halt4;
      @(posedge pclk) disable iff (!presetn)
         in_sleep && wake_hit |=> (state == CCS_ST_HALT)[*4] ##1 state == CCS_ST_ACTIVE;
   endproperty
   a_halt4: assert property (p_halt4) else $error("wake halt not four cycles");
   property p_sleep_gate;
      @(posedge pclk) disable iff (!presetn) cpu_run && !sleep_en |=> state != CCS_ST_SLEEP;
   endproperty
   a_sleep_gate: assert property (p_sleep_gate) else $error("sleep without enable");
   property p_pll_range;
      @(posedge pclk) disable iff (!presetn) wr_en && hit_x && wr_pllf == 5'h00 |=>
         pll_factor == $past(pll_factor) && pll_factor != 5'h00;
   endproperty
   a_pll_range: assert property (p_pll_range) else $error("pll factor zero accepted");
   property p_pdown_wake;
      @(posedge pclk) disable iff (!presetn)
         in_sleep && smode == 3'(CCS_PDOWN) && !wake_async |=> state == CCS_ST_SLEEP;
   endproperty
   a_pdown_wake: assert property (p_pdown_wake) else $error("bad power-down wake");
   property p_pr_freeze;
      @(posedge pclk) disable iff (!presetn) pr[0] && $past(pr[0]) |-> !per_clk_en[0];
   endproperty
   a_pr_freeze: assert property (p_pr_freeze) else $error("gated peripheral clocked");
   property p_src_ready;
      @(posedge pclk) disable iff (!presetn)
         cur_sel != $past(cur_sel) && !$past(fail_hit) |->
         |($past(src_ready) & (CCS_NSRC'(1) << cur_sel));
   endproperty
   a_src_ready: assert property (p_src_ready) else $error("switched to unready source");
   property p_idle_run;
      @(posedge pclk) disable iff (!presetn) in_sleep && m_idle && pif.per4_tick |=>
         per4_clk_en && !cpu_clk_en;
   endproperty
   a_idle_run: assert property (p_idle_run) else $error("idle clock gating wrong");
endmodule // ccs_clock_sleep_ctrl

/* testbench/ccs_osc_model.sv */
`timescale 1ns/1ps
module ccs_osc_model
   import ccs_pkg::*;
(
   // clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // oscillator side
   input  wire logic [CCS_NSRC-1:0] osc_en,
   output logic      [CCS_NSRC-1:0] src_tick,
   output logic      [CCS_NSRC-1:0] src_ready,
   output logic                     slow_idle_tick,
   output logic                     rc32k_tick
);
   logic [1:0] phase;
   // a disabled source gives no edges and never reports stable
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase     <= 2'h0;
         src_ready <= '0;
      end
      else
      begin
         phase     <= phase + 2'h1;
         src_ready <= osc_en;
      end
   end
   assign src_tick       = osc_en & {CCS_NSRC{phase[0]}};
   assign slow_idle_tick = (phase == 2'h3);
   assign rc32k_tick     = (phase == 2'h1);
endmodule // ccs_osc_model

/* testbench/clock_and_sleep_control_tb_top.sv */
`timescale 1ns/1ps
`include "ccs_defines.svh"
module clock_and_sleep_control_tb_top
   import ccs_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [4:0] src_tick, src_ready, osc_en, pll_factor;
   logic xosc_fail, pll_fail, slow_idle_tick, slow_idle_used, rc32k_tick, sie, slow_1k, rc_1k;
   logic [1:0] fcl_en, xosc_mode, pll_ref;
   logic [7:0] rc32k_cal, per_clk_en;
   logic cpu_clk_en, nvm_clk_en, per2, per4, rtc_run, lcd_run, nmi, sleep_instr, irq_any;
   logic wake_async, wake_rtc, wake_lcd, rtc_en, lcd_en, nvm_busy, cpu_halt, wake_pulse, er;
   int err_total = 0;
   int cmp_count = 0;

   ccs_clock_sleep_ctrl i_ccs_clock_sleep_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .src_tick(src_tick), .src_ready(src_ready),
      .xosc_fail(xosc_fail), .pll_fail(pll_fail), .slow_idle_tick(slow_idle_tick),
      .slow_idle_used(slow_idle_used), .rc32k_tick(rc32k_tick), .osc_en(osc_en),
      .slow_idle_oscillator_en(sie), .frequency_calibration_loop_en(fcl_en),
      .xosc_mode(xosc_mode), .pll_factor(pll_factor), .pll_ref(pll_ref), .rc32k_cal(rc32k_cal),
      .slow_1k_tick(slow_1k), .rc32k_1k_tick(rc_1k), .cpu_clk_en(cpu_clk_en),
      .nvm_clk_en(nvm_clk_en), .per_clk_en(per_clk_en), .per2_clk_en(per2), .per4_clk_en(per4),
      .rtc_clk_run(rtc_run), .lcd_clk_run(lcd_run), .nmi(nmi), .sleep_instr(sleep_instr),
      .irq_any(irq_any), .wake_async(wake_async), .wake_rtc(wake_rtc), .wake_lcd(wake_lcd),
      .rtc_en(rtc_en), .lcd_en(lcd_en), .nvm_busy(nvm_busy), .cpu_halt(cpu_halt),
      .wake_pulse(wake_pulse));
   ccs_osc_model i_ccs_osc_model (.pclk(pclk), .presetn(presetn), .osc_en(osc_en),
      .src_tick(src_tick), .src_ready(src_ready), .slow_idle_tick(slow_idle_tick),
      .rc32k_tick(rc32k_tick));

   initial
   begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // one apb transfer; the request holds until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle cycle lets the last write settle before the caller looks
      @(posedge pclk);
      if (n >= 20) chk(1'b0, 1'b1, "apb timeout");
   endtask

   task automatic t_reset();
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk(osc_en, 5'h0_0, "osc off in reset");
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(osc_en, 5'h0_1, "only 2MHz on");
      chk({fcl_en, pll_factor}, 7'h0_1, "loops off");
      chk(rc32k_cal, 8'h8_0, "cal reset");
      apb(1'b0, `CCS_OFF_STATUS, 32'h0000_0000);
      chk(rd[10:8], 3'h0, "start source");
      apb(1'b0, 12'h0_40, 32'h0000_0000);
      chk(er, 1'b1, "unmapped error");
      chk(rd, 32'h0000_0000, "unmapped read zero");
      $display("test reset done");
   endtask

   task automatic t_regs();
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, `CCS_OFF_XOSC, m * 32'h0000_4001 + 32'h0000_1F00);
         chk({pll_ref, xosc_mode, pll_factor}, m * 160 + 31, "mode ref factor");
      end
      // factor 0 is refused, 31 stays
      apb(1'b1, `CCS_OFF_XOSC, 32'h0000_0000);
      chk(pll_factor, 5'h1_F, "factor zero");
      apb(1'b1, `CCS_OFF_CAL, 32'h0000_005A);
      apb(1'b0, `CCS_OFF_CAL, 32'h0000_0000);
      chk({rc32k_cal, rd[7:0]}, 16'h5A5A, "cal");
      $display("test regs done");
   endtask

   // ratio clamp, tick rates, peripheral gating and the low-rate outputs
   task automatic t_misc();
      int c4 = 0;
      int c2 = 0;
      int cc = 0;
      int p0 = 0;
      int p1 = 0;
      int nv = 0;
      int ph = 0;
      int s1k = 0;
      int r1k = 0;
      apb(1'b1, `CCS_OFF_CLKSEL, 32'h0000_00F0);
      apb(1'b0, `CCS_OFF_CLKSEL, 32'h0000_0000);
      chk(rd[7:4], `CCS_DIV_MAX, "ratio clamp");
      apb(1'b1, `CCS_OFF_CLKSEL, 32'h0000_0010);
      apb(1'b1, `CCS_OFF_PR, 32'h0000_0001);
      slow_idle_used <= 1'b1;
      repeat (8) @(posedge pclk);
      chk(sie, 1'b1, "slow oscillator on demand");
      // the window spans whole periods of every tick, so counts are exact
      repeat (256)
      begin
         @(negedge pclk);
         c4 += (per4 === 1'b1);
         c2 += (per2 === 1'b1);
         cc += (cpu_clk_en === 1'b1);
         p0 += (per_clk_en[0] === 1'b1);
         p1 += (per_clk_en[1] === 1'b1);
         nv += (nvm_clk_en === 1'b1);
         ph += (cpu_clk_en === 1'b1) && !(per2 === 1'b1 && per4 === 1'b1);
         s1k += (slow_1k === 1'b1);
         r1k += (rc_1k === 1'b1);
      end
      chk(cc, 16, "cpu rate at ratio 2");
      chk(c4, 4 * cc, "per4 rate");
      chk(c2, 2 * cc, "per2 rate");
      chk(ph, 0, "fast clocks in phase");
      chk(p0, 0, "gated peripheral frozen");
      chk(p1, cc, "ungated peripheral");
      chk(nv, cc, "nvm clock in active");
      chk(s1k, 2, "slow 1k output");
      chk(r1k, 2, "rc32k 1k output");
      chk({rtc_run, lcd_run}, 2'h3, "rtc and display run in active");
      apb(1'b1, `CCS_OFF_PR, 32'h0000_0000);
      slow_idle_used <= 1'b0;
      $display("test misc done");
   endtask

   task automatic t_fail();
      int n;
      n = 0;
      apb(1'b1, `CCS_OFF_OSCEN, 32'h0000_0009);
      apb(1'b1, `CCS_OFF_CFD, 32'h0000_0001);
      apb(1'b1, `CCS_OFF_CLKSEL, 32'h0000_0003);
      repeat (40) @(posedge pclk);
      apb(1'b0, `CCS_OFF_STATUS, 32'h0000_0000);
      chk(rd[10:8], 3'h3, "switched");
      xosc_fail <= 1'b1;
      do
      begin
         @(negedge pclk);
         n++;
      end while (nmi !== 1'b1 && n < 5);
      chk(nmi, 1'b1, "nmi");
      @(posedge pclk);
      apb(1'b0, `CCS_OFF_STATUS, 32'h0000_0000);
      chk({rd[12], rd[10:8]}, 4'h8, "fallback");
      apb(1'b1, `CCS_OFF_STATUS, 32'h0000_0100);
      apb(1'b0, `CCS_OFF_STATUS, 32'h0000_0000);
      chk(rd[12], 1'b0, "flag clear");
      xosc_fail <= 1'b0;
      $display("test fail done");
   endtask

   // enter sleep, count peripheral enables, then wake and time the halt
   task automatic t_sleep(input logic [3:0] cfg, input logic bad_wake, input int per_exp);
      int n;
      n = 0;
      apb(1'b1, `CCS_OFF_SLEEP, {28'h000_0000, cfg});
      sleep_instr <= 1'b1;
      @(posedge pclk);
      sleep_instr <= 1'b0;
      irq_any <= bad_wake;
      // enables launched at the entry edge still belong to active mode
      @(posedge pclk);
      repeat (16)
      begin
         @(negedge pclk);
         n += (per_clk_en[0] === 1'b1) + 2 * (cpu_clk_en === 1'b1);
      end
      chk(cpu_halt, cfg[0], "sleep entry");
      chk(n > 0, per_exp, "peripheral clock in sleep");
      chk({rtc_run, lcd_run}, {2{!cfg[0] || cfg[3:1] == 3'h0}}, "rtc display clocks");
      chk(osc_en[0], !cfg[0] || cfg[3:1] == 3'h0 || cfg[3:1] >= 3'h3, "sources kept");
      @(posedge pclk);
      wake_async <= cfg[0];
      irq_any <= cfg[0];
      n = 0;
      for (int i = 0; i < 6; i++)
      begin
         @(negedge pclk);
         n += (wake_pulse === 1'b1);
         chk(cpu_halt, cfg[0] && i < 5, "halt after wake");
      end
      chk(n, cfg[0], "one wake pulse");
      @(posedge pclk);
      wake_async <= 1'b0;
      irq_any <= 1'b0;
      $display("test sleep done");
   endtask

   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      {presetn, psel, penable, pwrite, paddr, pwdata, xosc_fail, pll_fail} = '0;
      {slow_idle_used, sleep_instr, irq_any, wake_async, wake_rtc, wake_lcd} = '0;
      {rtc_en, lcd_en, nvm_busy} = '0;
      @(posedge pclk);
      t_reset();
      t_regs();
      t_misc();
      t_fail();
      t_reset();
      t_sleep(4'h0, 1'b0, 1);
      t_sleep(4'h1, 1'b0, 1);
      t_sleep(4'h3, 1'b1, 0);
      t_sleep(4'h5, 1'b1, 0);
      t_sleep(4'h7, 1'b1, 0);
      t_sleep(4'h9, 1'b1, 0);
      close_out();
   end

   initial
   begin
      #100000;
      err_total++;
      close_out();
   end
endmodule // clock_and_sleep_control_tb_top
